// >>> logic/stream_if.sv
// Valid/ready byte stream between the data path and its buffers
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// >>> logic/tape_buffer_dma_datapath.sv
// Buffer RAM, refresh, DMA channels and tape FIFOs of the interface board
`timescale 1ns/1ps
`default_nettype none
`include "tape_dma_cfg.svh"
module tape_buffer_dma_datapath
  import tape_dma_pkg::*;
(
  input  wire logic        clk,            // 10 MHz system clock
  input  wire logic        reset,          // Synchronous, active high
  input  wire logic        clkEn,          // Freezes all state when low
  input  wire logic        cpuReq,         // Processor buffer access
  input  wire logic        cpuWe,          // Access is a write
  input  wire logic [19:0] cpuAddr,        // Buffer word address
  input  wire logic [7:0]  cpuWrData,      // Byte to store
  output logic             cpuAck,         // Access taken this cycle
  output logic             cpuRdValid,     // Read byte valid
  output logic [7:0]       cpuRdData,      // Read byte
  input  wire logic        progWe,         // Load a channel
  input  wire logic [1:0]  progCh,         // Channel to load
  input  wire logic [19:0] progAddr,       // Offset into data area
  input  wire logic [15:0] progCount,      // Byte count minus one
  input  wire dma_mode_t   progMode,       // Transfer mode
  input  wire logic        progToMem,      // Into buffer when high
  input  wire logic        tapeInterleave, // Chain channels 0 and 1
  output logic [3:0]       chBusy,         // Channel armed
  output logic [3:0]       chDone,         // Channel count ended
  output logic             refreshStrobe,  // Refresh cycle slot
  input  wire logic        scsiDreq,       // SCSI DMA request
  output logic             scsiDack,       // SCSI DMA acknowledge
  input  wire logic [7:0]  scsiRdData,     // Byte from SCSI side
  output logic             scsiWrStrobe,   // Byte to SCSI valid
  output logic [7:0]       scsiWrData,     // Byte to SCSI side
  input  wire logic        scsiIrq,        // SCSI operation ended
  input  wire logic        tapeWrStrobe,   // Pin: tape took byte
  output logic [7:0]       tapeWrData,     // Pin: write byte
  output logic             tapeWrParity,   // Pin: odd parity
  output logic             tapeWrValid,    // Pin: write byte ready
  input  wire logic        tapeRdStrobe,   // Pin: read byte strobe
  input  wire logic [7:0]  tapeRdData,     // Pin: read byte
  input  wire logic        tapeRdParity,   // Pin: read parity
  output logic             tapeRdHold,     // Read FIFO full
  input  wire logic        tapeDoneLine,   // Pin: transfer done
  output logic [1:0]       irqPending,     // 1 SCSI, 0 tape
  input  wire logic [1:0]  irqClr,         // Clear pending bits
  output logic             parityErr,      // Read parity failed
  input  wire logic        parityErrClr    // Clear parity flag
);
  localparam int GAP = int'((`REFRESH_WINDOW_MS * `NS_PER_MS) /
                            (`REFRESH_CYCLES * `CLK_PERIOD_NS));

  function automatic logic oddPar(input logic [7:0] d);
    oddPar = ~^d;
  endfunction

  stream_if #(.W(9)) wrIn ();
  stream_if #(.W(9)) wrMid ();
  stream_if #(.W(9)) skOut ();
  stream_if #(.W(9)) rdIn ();
  stream_if #(.W(9)) rdOut ();

  logic [8:0]  mem [0:`BUF_WORDS-1];
  logic [8:0]  memQ_reg;
  rd_owner_t   owner_reg;
  logic [11:0] pinS1_reg;
  logic [11:0] pinS2_reg;
  logic [2:0]  strbPrev_reg;
  logic        scsiIrqPrev_reg;
  logic [1:0]  irq_reg;
  logic        parErr_reg;
  logic [7:0]  refCnt_reg;
  logic [19:0] chAddr_reg [4];
  logic [15:0] chCount_reg [4];
  dma_mode_t   chMode_reg [4];
  logic [3:0]  chActive_reg;
  logic [3:0]  chToMem_reg;
  logic [3:0]  chDone_reg;
  logic        tapeCur_reg;
  logic        lock_reg;
  logic [1:0]  lockCh_reg;
  logic        lastScsi_reg;
  logic        outValid_reg;
  logic [8:0]  outByte_reg;
  logic [4:0]  wrLevel;
  logic [3:0]  reqCh;

  // Pin inputs, two flops then edge detect
  wire [2:0] strbRise = pinS2_reg[11:9] & ~strbPrev_reg;
  wire       wrTake   = strbRise[2];
  wire       rdTake   = strbRise[1];
  wire       doneRise = strbRise[0];
  wire [8:0] rdByte   = pinS2_reg[8:0];
  wire       rdBad    = rdByte[8] != oddPar(rdByte[7:0]);
  wire       scsiRise = scsiIrq & ~scsiIrqPrev_reg;

  wire refreshSlot = refCnt_reg == 8'h00;
  wire [7:0] refNext = refreshSlot ? 8'(GAP - 1) : refCnt_reg - 8'h01;

  // Request per channel
  wire tapeSpace = (wrLevel + {4'h0, owner_reg == OWN_TAPE})
                   < 5'(`TAPE_FIFO_DEPTH);
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tapeReq
      assign reqCh[gi] = chActive_reg[gi] & (tapeCur_reg == 1'(gi)) &
                         (chToMem_reg[gi] ? rdOut.valid : tapeSpace);
    end
  endgenerate
  assign reqCh[2] = 1'b0;
  assign reqCh[3] = chActive_reg[3] & scsiDreq;

  // Arbitration
  wire [1:0] tapeIdx  = {1'b0, tapeCur_reg};
  wire       tapeWins = reqCh[tapeIdx] & (~reqCh[3] | lastScsi_reg);
  wire [1:0] pickCh   = tapeWins ? tapeIdx : `SCSI_CH;
  wire lockHold = lock_reg & ((chMode_reg[lockCh_reg] == MODE_BURST) |
                  reqCh[lockCh_reg]);
  wire gntDma = ~refreshSlot & (lockHold ? reqCh[lockCh_reg]
                : (~cpuReq & |reqCh));
  wire [1:0] gntCh  = lockHold ? lockCh_reg : pickCh;
  wire       gntCpu = ~refreshSlot & ~lockHold & cpuReq;
  wire       term   = chCount_reg[gntCh] == 16'h0000;
  wire       toMem  = chToMem_reg[gntCh];

  // Memory port
  wire [19:0] memAddr  = gntCpu ? cpuAddr
                       : chAddr_reg[gntCh] + `STACK_WORDS;
  wire [7:0]  dmaByte  = gntCh[1] ? scsiRdData : rdOut.data[7:0];
  wire [7:0]  memByte  = gntCpu ? cpuWrData : dmaByte;
  wire [8:0]  memWData = {oddPar(memByte), memByte};
  wire        memWe    = gntCpu ? cpuWe : (gntDma & toMem);
  wire        memRd    = (gntCpu & ~cpuWe) | (gntDma & ~toMem);
  wire rd_owner_t ownNext = ~memRd ? OWN_NONE : gntCpu ? OWN_CPU
                          : gntCh[1] ? OWN_SCSI : OWN_TAPE;

  assign rdOut.ready  = gntDma & ~gntCh[1] & toMem;
  assign wrIn.valid   = owner_reg == OWN_TAPE;
  assign wrIn.data    = memQ_reg;
  assign rdIn.valid   = rdTake;
  assign rdIn.data    = rdByte;
  assign tapeRdHold   = ~rdIn.ready;
  assign skOut.ready  = ~outValid_reg | wrTake;
  wire   outLoad      = skOut.valid & skOut.ready;

  assign cpuAck        = gntCpu;
  assign cpuRdValid    = owner_reg == OWN_CPU;
  assign cpuRdData     = memQ_reg[7:0];
  assign scsiDack      = (gntDma & (gntCh == `SCSI_CH) & toMem)
                       | (owner_reg == OWN_SCSI);
  assign scsiWrStrobe  = owner_reg == OWN_SCSI;
  assign scsiWrData    = memQ_reg[7:0];
  assign tapeWrData    = outByte_reg[7:0];
  assign tapeWrParity  = outByte_reg[8];
  assign tapeWrValid   = outValid_reg;
  assign chBusy        = chActive_reg;
  assign chDone        = chDone_reg;
  assign refreshStrobe = refreshSlot;
  assign irqPending    = irq_reg;
  assign parityErr     = parErr_reg;

  tape_fifo #(.W(9), .DEPTH(`TAPE_FIFO_DEPTH)) wrFifo (
    .clk(clk), .reset(reset), .clkEn(clkEn),
    .inPort(wrIn), .outPort(wrMid), .level(wrLevel));
  tape_fifo #(.W(9), .DEPTH(`SKID_DEPTH)) skid (
    .clk(clk), .reset(reset), .clkEn(clkEn),
    .inPort(wrMid), .outPort(skOut), .level());
  tape_fifo #(.W(9), .DEPTH(`TAPE_FIFO_DEPTH)) rdFifo (
    .clk(clk), .reset(reset), .clkEn(clkEn),
    .inPort(rdIn), .outPort(rdOut), .level());

  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (memWe & (gntCpu | gntDma)) begin
        mem[memAddr] <= memWData;
      end
      memQ_reg <= mem[memAddr];
      if (outLoad) begin
        outByte_reg <= skOut.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pinS1_reg       <= 12'h000;
      pinS2_reg       <= 12'h000;
      strbPrev_reg    <= 3'h0;
      scsiIrqPrev_reg <= 1'b0;
      irq_reg         <= 2'h0;
      parErr_reg      <= 1'b0;
      refCnt_reg      <= 8'(GAP - 1);
      owner_reg       <= OWN_NONE;
      outValid_reg    <= 1'b0;
    end else if (clkEn) begin
      pinS1_reg       <= {tapeWrStrobe, tapeRdStrobe, tapeDoneLine,
                          tapeRdParity, tapeRdData};
      pinS2_reg       <= pinS1_reg;
      strbPrev_reg    <= pinS2_reg[11:9];
      scsiIrqPrev_reg <= scsiIrq;
      irq_reg    <= (irq_reg & ~irqClr) | {scsiRise, doneRise};
      parErr_reg <= (parErr_reg & ~parityErrClr) | (rdTake & rdBad);
      refCnt_reg      <= refNext;
      owner_reg       <= ownNext;
      outValid_reg    <= outLoad | (outValid_reg & ~wrTake);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chActive_reg <= 4'h0;
      chToMem_reg  <= 4'h0;
      chDone_reg   <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        chAddr_reg[i]  <= 20'h00000;
        chCount_reg[i] <= 16'h0000;
        chMode_reg[i]  <= MODE_SINGLE;
      end
    end else if (clkEn) begin
      chDone_reg <= 4'h0;
      if (gntDma) begin
        chAddr_reg[gntCh]  <= chAddr_reg[gntCh] + 20'h00001;
        chCount_reg[gntCh] <= chCount_reg[gntCh] - 16'h0001;
        if (term) begin
          chActive_reg[gntCh] <= 1'b0;
          chDone_reg[gntCh]   <= 1'b1;
        end
      end
      if (progWe && progCh != `UNUSED_CH) begin
        chAddr_reg[progCh]   <= progAddr;
        chCount_reg[progCh]  <= progCount;
        chMode_reg[progCh]   <= progMode;
        chToMem_reg[progCh]  <= progToMem;
        chActive_reg[progCh] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tapeCur_reg  <= 1'b0;
      lock_reg     <= 1'b0;
      lockCh_reg   <= 2'h0;
      lastScsi_reg <= 1'b0;
    end else if (clkEn) begin
      if (!tapeInterleave) begin
        tapeCur_reg <= 1'b0;
      end else if (gntDma && !gntCh[1] && term) begin
        tapeCur_reg <= ~tapeCur_reg;
      end
      lock_reg <= gntDma ? (chMode_reg[gntCh] != MODE_SINGLE) & ~term
                         : lockHold;
      if (gntDma) begin
        lockCh_reg   <= gntCh;
        lastScsi_reg <= gntCh[1];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_stackGuard;
    gntDma |-> memAddr >= `STACK_WORDS;
  endproperty
  a_stackGuard: assert property (p_stackGuard)
    else $error("DMA address fell in the stack area");

  property p_parityStore;
    clkEn && memWe && (gntCpu || gntDma) |=>
      mem[$past(memAddr)][8] == ~^mem[$past(memAddr)][7:0];
  endproperty
  a_parityStore: assert property (p_parityStore)
    else $error("Stored byte lacks odd parity bit");

  property p_refreshSteal;
    refreshSlot |-> !gntCpu && !gntDma;
  endproperty
  a_refreshSteal: assert property (p_refreshSteal)
    else $error("Access granted in a refresh slot");

  property p_noChan2;
    gntDma |-> gntCh != `UNUSED_CH;
  endproperty
  a_noChan2: assert property (p_noChan2)
    else $error("Unused channel was granted");

  property p_fairShare;
    !lockHold && !refreshSlot && !cpuReq && reqCh[3] && reqCh[tapeIdx]
      |-> gntCh == (lastScsi_reg ? tapeIdx : `SCSI_CH);
  endproperty
  a_fairShare: assert property (p_fairShare)
    else $error("Tape and SCSI channels not alternated");

  property p_burstLock;
    clkEn && gntDma && chMode_reg[gntCh] == MODE_BURST && !term
      |=> lock_reg && lockCh_reg == $past(gntCh);
  endproperty
  a_burstLock: assert property (p_burstLock)
    else $error("Burst channel lost the bus");

  property p_normalTape;
    clkEn && !tapeInterleave |=> !tapeCur_reg;
  endproperty
  a_normalTape: assert property (p_normalTape)
    else $error("Channel 1 active without interleave");

  property p_interleave;
    clkEn && tapeInterleave && gntDma && !gntCh[1] && term
      |=> tapeCur_reg != $past(tapeCur_reg);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("Tape channel did not hand over");

  property p_irqEdge;
    clkEn && scsiRise |=> irqPending[1];
  endproperty
  a_irqEdge: assert property (p_irqEdge)
    else $error("SCSI rising edge not latched");

  property p_scsiOut;
    clkEn && gntDma && gntCh == `SCSI_CH && !toMem |=> scsiWrStrobe;
  endproperty
  a_scsiOut: assert property (p_scsiOut)
    else $error("SCSI data byte not delivered");

  property p_wrParity;
    tapeWrValid |-> tapeWrParity == oddPar(tapeWrData);
  endproperty
  a_wrParity: assert property (p_wrParity)
    else $error("Tape write parity is not odd");

  property p_rdCheck;
    clkEn && rdTake && rdBad |=> parityErr;
  endproperty
  a_rdCheck: assert property (p_rdCheck)
    else $error("Bad read parity not flagged");

  property p_errSticky;
    parityErr && !parityErrClr |=> parityErr;
  endproperty
  a_errSticky: assert property (p_errSticky)
    else $error("Parity flag dropped without clear");

endmodule : tape_buffer_dma_datapath
`default_nettype wire

// >>> logic/tape_dma_cfg.svh
// Constants for the tape buffer DMA data path
// How it works
// - Lowest 3k is stack, rest buffers data
// - Every stored byte gets a ninth parity bit
// - Refresh averages 256 cycles per 4 ms
// - Channels 0,1 serve tape; 3 serves SCSI
// - Tape and SCSI channels run side by side
// - Single, burst or demand mode per channel
// - Tape channels share one request path; 0 normal
// - Over 64K, channels 0 and 1 alternate
// - Interrupt requests are caught on rising edges
// - Program access for commands, DMA for data
// - 16-byte FIFO on tape write and read
// - Stored ninth bit goes out as odd parity
// - Tape read bytes checked for odd parity
`ifndef TAPE_DMA_CFG_SVH
`define TAPE_DMA_CFG_SVH

`define BUF_WORDS         20'hBB800
`define STACK_WORDS       20'h00C00
`define REFRESH_CYCLES    32'h100
`define REFRESH_WINDOW_MS 32'h4
`define NS_PER_MS         32'hF4240
`define CLK_PERIOD_NS     32'h64
`define TAPE_FIFO_DEPTH   16
`define SKID_DEPTH        2
`define SCSI_CH           2'h3
`define UNUSED_CH         2'h2

`endif

// >>> logic/tape_dma_pkg.sv
// Types for the tape buffer DMA data path
package tape_dma_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_BURST  = 2'h1,
    MODE_DEMAND = 2'h3
  } dma_mode_t;

  typedef enum logic [1:0] {
    OWN_NONE = 2'h0,
    OWN_CPU  = 2'h1,
    OWN_TAPE = 2'h3,
    OWN_SCSI = 2'h2
  } rd_owner_t;

endpackage : tape_dma_pkg

// >>> logic/tape_fifo.sv
// Parameterised valid/ready FIFO used on the tape paths
`timescale 1ns/1ps
`default_nettype none
module tape_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic                clk,     // System clock
  input  wire logic                reset,   // Synchronous reset
  input  wire logic                clkEn,   // Freezes state when low
  stream_if.snk                    inPort,  // Filling side
  stream_if.src                    outPort, // Draining side
  output logic [$clog2(DEPTH):0]   level    // Entries held
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  store [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0]   count_reg;

  wire push = inPort.valid & inPort.ready;
  wire pop  = outPort.valid & outPort.ready;

  assign inPort.ready  = count_reg != (AW+1)'(DEPTH);
  assign outPort.valid = count_reg != '0;
  assign outPort.data  = store[rdPtr_reg];
  assign level         = count_reg;

  always_ff @(posedge clk) begin
    if (clkEn && push) begin
      store[wrPtr_reg] <= inPort.data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  property p_fifoCount;
    @(posedge clk) disable iff (reset)
      clkEn && push && !pop |=> count_reg == $past(count_reg) + 1'b1;
  endproperty
  a_fifoCount: assert property (p_fifoCount)
    else $error("FIFO count did not rise on a push");

endmodule : tape_fifo
`default_nettype wire

// >>> tb/tape_unit_model.sv
// Tape unit model: takes write bytes, sends read bytes, pulses done
`timescale 1ns/1ps
`default_nettype none
module tape_unit_model (
  input  wire logic       clk,          // System clock
  input  wire logic [7:0] tapeWrData,   // Write byte
  input  wire logic       tapeWrParity, // Write parity
  input  wire logic       tapeWrValid,  // Write byte ready
  output logic            tapeWrStrobe, // Byte taken
  output logic            tapeRdStrobe, // Read byte strobe
  output logic [7:0]      tapeRdData,   // Read byte
  output logic            tapeRdParity, // Read parity
  output logic            tapeDoneLine, // Transfer done
  output logic            gotByte,      // Word captured
  output logic [8:0]      gotWord       // Parity and byte
);
  initial begin
    tapeWrStrobe = 1'b0;
    tapeRdStrobe = 1'b0;
    tapeRdData   = 8'h5A;
    tapeRdParity = 1'b1;
    tapeDoneLine = 1'b0;
    gotByte      = 1'b0;
    gotWord      = 9'h000;
  end

  // Strobe high 2 clocks, low 4, so edges stay well apart
  initial begin
    forever begin
      @(posedge clk);
      if (tapeWrValid === 1'b1) begin
        gotWord      <= {tapeWrParity, tapeWrData};
        gotByte      <= 1'b1;
        tapeWrStrobe <= 1'b1;
        @(posedge clk);
        gotByte <= 1'b0;
        @(posedge clk);
        tapeWrStrobe <= 1'b0;
        repeat (3) @(posedge clk);
      end
    end
  end

  // Data held two clocks before the strobe rises and one clock after it falls
  task automatic sendRead(input logic [7:0] b, input logic p);
    @(posedge clk);
    tapeRdData   <= b;
    tapeRdParity <= p;
    repeat (2) @(posedge clk);
    tapeRdStrobe <= 1'b1;
    repeat (3) @(posedge clk);
    tapeRdStrobe <= 1'b0;
    @(posedge clk);
    tapeRdData   <= ~b;
    tapeRdParity <= ~p;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulseDone();
    @(posedge clk);
    tapeDoneLine <= 1'b1;
    repeat (3) @(posedge clk);
    tapeDoneLine <= 1'b0;
  endtask
endmodule // tape_unit_model
`default_nettype wire

// >>> tb/test_tape_buffer_dma_datapath.sv
// Self-checking bench for the tape buffer DMA data path
`timescale 1ns/1ps
`default_nettype none
`include "tape_dma_cfg.svh"
`define CHK(nm, ex, got) begin \
  testsRun++; \
  if ((ex) !== (got)) begin \
    mismatches++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); \
  end \
end
module test_tape_buffer_dma_datapath
  import tape_dma_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, cpuReq = 1'b0, cpuWe = 1'b0;
  logic [19:0] cpuAddr = 20'h00000, progAddr = 20'h00000;
  logic [7:0]  cpuWrData = 8'h00, scsiRdData = 8'h00;
  logic        progWe = 1'b0, progToMem = 1'b0, tapeInterleave = 1'b0;
  logic [1:0]  progCh = 2'h0, irqClr = 2'h0;
  logic [15:0] progCount = 16'h0000;
  dma_mode_t   progMode = MODE_SINGLE;
  logic        scsiDreq = 1'b0, scsiIrq = 1'b0, parityErrClr = 1'b0;
  logic        cpuAck, cpuRdValid, refreshStrobe, scsiDack, scsiWrStrobe;
  logic [7:0]  cpuRdData, scsiWrData, tapeWrData, tapeRdData;
  logic [3:0]  chBusy, chDone;
  logic [1:0]  irqPending;
  logic        tapeWrStrobe, tapeWrParity, tapeWrValid, tapeRdStrobe;
  logic        tapeRdParity, tapeDoneLine, parityErr, gotByte, tapeRdHold;
  logic [8:0]  gotWord;
  logic [31:0] seed = 32'h0000D5CC;
  logic [7:0]  model [0:255];
  logic [7:0]  cpuQ [$];
  logic [8:0]  tapeQ [$];
  logic [7:0]  scsiQ [$];
  logic        scsiIn = 1'b0;
  int          scsiPtr = 0;
  int          mismatches = 0;
  int          testsRun = 0;
  int          doneCnt = 0;
  logic        clkEn = 1'b1;

  tape_buffer_dma_datapath dut (
    .clk, .reset, .clkEn, .cpuReq, .cpuWe, .cpuAddr, .cpuWrData,
    .cpuAck, .cpuRdValid, .cpuRdData, .progWe, .progCh, .progAddr,
    .progCount, .progMode, .progToMem, .tapeInterleave, .chBusy,
    .chDone, .refreshStrobe, .scsiDreq, .scsiDack, .scsiRdData,
    .scsiWrStrobe, .scsiWrData, .scsiIrq, .tapeWrStrobe, .tapeWrData,
    .tapeWrParity, .tapeWrValid, .tapeRdStrobe, .tapeRdData,
    .tapeRdParity, .tapeRdHold, .tapeDoneLine, .irqPending, .irqClr,
    .parityErr, .parityErrClr
  );

  tape_unit_model tape (
    .clk, .tapeWrData, .tapeWrParity, .tapeWrValid, .tapeWrStrobe,
    .tapeRdStrobe, .tapeRdData, .tapeRdParity, .tapeDoneLine, .gotByte,
    .gotWord
  );

  always #50 clk = ~clk;

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  always @(posedge clk) scsiRdData <= rnd();

  // Result watcher: oldest note against each result
  always @(posedge clk) begin : watch
    logic [8:0] e;
    if (cpuRdValid === 1'b1) begin
      e = {1'b0, cpuQ.pop_front()};
      `CHK("cpuRdData", e[7:0], cpuRdData)
    end
    if (gotByte === 1'b1) begin
      e = tapeQ.pop_front();
      `CHK("tapeWord", e, gotWord)
    end
    if (scsiWrStrobe === 1'b1) begin
      e = {1'b0, scsiQ.pop_front()};
      `CHK("scsiWrData", e[7:0], scsiWrData)
    end
    for (int i = 0; i < 4; i++)
      if (chDone[i] === 1'b1) doneCnt++;
    if (scsiIn && scsiDack === 1'b1) begin
      model[scsiPtr] = scsiRdData;
      scsiPtr++;
    end
  end

  task automatic report_and_stop();
    if (mismatches == 0 && testsRun > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic waitAck();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (cpuAck !== 1'b1 && i < 1000);
    `CHK("cpuAck", 1'b1, cpuAck)
  endtask

  task automatic cpuWrite(input logic [19:0] a, input logic [7:0] d);
    cpuReq    <= 1'b1;
    cpuWe     <= 1'b1;
    cpuAddr   <= a;
    cpuWrData <= d;
    waitAck();
    if (a >= `STACK_WORDS && a < `STACK_WORDS + 256)
      model[a - `STACK_WORDS] = d;
  endtask

  task automatic cpuRead(input logic [19:0] a, input logic [7:0] ex);
    cpuReq  <= 1'b1;
    cpuWe   <= 1'b0;
    cpuAddr <= a;
    waitAck();
    cpuQ.push_back(ex);
  endtask

  task automatic prog(input logic [1:0] ch, input logic [19:0] off,
                      input logic [15:0] cnt, input dma_mode_t m,
                      input logic toMem);
    progWe    <= 1'b1;
    progCh    <= ch;
    progAddr  <= off;
    progCount <= cnt;
    progMode  <= m;
    progToMem <= toMem;
    @(posedge clk);
    progWe <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitIdle(input logic [3:0] mask);
    int i;
    i = 0;
    while ((chBusy & mask) !== 4'h0 && i < 3000) begin
      @(posedge clk);
      i++;
    end
    `CHK("chBusy", 4'h0, chBusy & mask)
  endtask

  task automatic expOut(input int off, input int n, input logic tp,
                        input logic sc);
    for (int j = off; j < off + n; j++) begin
      if (tp) tapeQ.push_back({~^model[j], model[j]});
      if (sc) scsiQ.push_back(model[j]);
    end
  endtask

  initial begin : watchdog
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin : main
    int n;
    logic [7:0] b;
    dma_mode_t modes [3];
    modes = '{MODE_SINGLE, MODE_BURST, MODE_DEMAND};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK("chBusy", 4'h0, chBusy)
    `CHK("irqPending", 2'h0, irqPending)
    `CHK("parityErr", 1'b0, parityErr)
    n = 0;
    while (refreshStrobe !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    // Ten frozen cycles push the next slot back by ten
    clkEn <= 1'b0;
    repeat (10) @(posedge clk);
    clkEn <= 1'b1;
    n = 11;
    while (refreshStrobe !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK("refreshGap", 156 + 10, n)
    for (int k = 0; k < 16; k++) cpuWrite(20'(`STACK_WORDS + k), rnd());
    // Stack word 0 must not alias data offset 0
    cpuWrite(20'h00000, ~model[0]);
    cpuRead(20'h00000, ~model[0]);
    for (int k = 0; k < 4; k++) cpuRead(20'(`STACK_WORDS + k), model[k]);
    cpuReq <= 1'b0;
    @(posedge clk);
    // Tape and SCSI channels out of the buffer together, every mode
    foreach (modes[k]) begin
      expOut(4 * k, 4, 1'b1, 1'b1);
      prog(2'h0, 20'(4 * k), 16'h0003, modes[k], 1'b0);
      prog(`SCSI_CH, 20'(4 * k), 16'h0003, modes[k], 1'b0);
      scsiDreq <= 1'b1;
      waitIdle(4'b1001);
      scsiDreq <= 1'b0;
      @(posedge clk);
    end
    // Channel 1 carries on where channel 0 ends
    tapeInterleave <= 1'b1;
    expOut(0, 2, 1'b1, 1'b0);
    expOut(8, 2, 1'b1, 1'b0);
    prog(2'h0, 20'h00000, 16'h0001, MODE_BURST, 1'b0);
    prog(2'h1, 20'h00008, 16'h0001, MODE_BURST, 1'b0);
    waitIdle(4'b0011);
    tapeInterleave <= 1'b0;
    // Tape read, second byte with even parity
    prog(2'h0, 20'h00040, 16'h0003, MODE_DEMAND, 1'b1);
    for (int j = 0; j < 4; j++) begin
      b = rnd();
      model[8'h40 + j] = b;
      tape.sendRead(b, (j == 1) ? ^b : ~^b);
      repeat (2) @(posedge clk);
      `CHK("parityErr", (j >= 1), parityErr)
    end
    waitIdle(4'b0001);
    parityErrClr <= 1'b1;
    @(posedge clk);
    parityErrClr <= 1'b0;
    @(posedge clk);
    `CHK("parityErrClr", 1'b0, parityErr)
    for (int j = 0; j < 4; j++)
      cpuRead(20'(`STACK_WORDS + 'h40 + j), model[8'h40 + j]);
    cpuReq <= 1'b0;
    // Read FIFO fills with no channel to drain it
    for (int j = 0; j < 16; j++) begin
      tape.sendRead(8'h00, 1'b1);
      `CHK("tapeRdHold", (j == 15), tapeRdHold)
    end
    prog(2'h0, 20'h000C0, 16'h000F, MODE_BURST, 1'b1);
    waitIdle(4'b0001);
    `CHK("tapeRdDrain", 1'b0, tapeRdHold)
    // A level left high must not set the bit again
    scsiIrq <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("irqScsi", 1'b1, irqPending[1])
    irqClr <= 2'b10;
    @(posedge clk);
    irqClr <= 2'b00;
    repeat (3) @(posedge clk);
    `CHK("irqScsiHeld", 1'b0, irqPending[1])
    scsiIrq <= 1'b0;
    tape.pulseDone();
    repeat (4) @(posedge clk);
    `CHK("irqTape", 1'b1, irqPending[0])
    irqClr <= 2'b01;
    @(posedge clk);
    irqClr <= 2'b00;
    @(posedge clk);
    `CHK("irqClr", 2'h0, irqPending)
    // SCSI data phase into the buffer
    scsiIn  = 1'b1;
    scsiPtr = 'h80;
    prog(`SCSI_CH, 20'h00080, 16'h0003, MODE_SINGLE, 1'b1);
    scsiDreq <= 1'b1;
    waitIdle(4'b1000);
    scsiDreq <= 1'b0;
    @(posedge clk);
    scsiIn = 1'b0;
    `CHK("scsiBytes", 'h84, scsiPtr)
    for (int j = 0; j < 4; j++)
      cpuRead(20'(`STACK_WORDS + 'h80 + j), model[8'h80 + j]);
    cpuReq <= 1'b0;
    repeat (200) @(posedge clk);
    `CHK("tapeLeft", 0, tapeQ.size())
    `CHK("scsiLeft", 0, scsiQ.size())
    `CHK("cpuLeft", 0, cpuQ.size())
    `CHK("chDone", 11, doneCnt)
    report_and_stop();
  end
endmodule // test_tape_buffer_dma_datapath
`default_nettype wire
